// ### gpm_pkg.sv
package gpm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    // printed offset 0x13 is not a multiple of four: kept as index
    localparam logic [7:0]  GPM_CTL_INDEX     = 8'h13;
    localparam logic [11:0] GPM_CTL_ADDR      = {2'h0, GPM_CTL_INDEX, 2'h0};
    localparam logic [7:0]  GPM_CTL_RESET     = 8'h00;
    localparam int          GPM_EN_BIT        = 0;
    localparam int          GPM_VAL_BIT       = 1;
    localparam int          GPM_SRC_LSB       = 2;
    localparam int          GPM_SEL_LSB       = 5;

    // ------------------------------------------------------------------
    // source group codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  GPM_SRC_STATUS    = 3'h4;
    localparam logic [2:0]  GPM_SRC_TX        = 3'h6;

    // ------------------------------------------------------------------
    // select codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  GPM_SEL_0         = 3'h0;
    localparam logic [2:0]  GPM_SEL_1         = 3'h1;
    localparam logic [2:0]  GPM_SEL_2         = 3'h2;
    localparam logic [2:0]  GPM_SEL_3         = 3'h3;
    localparam logic [2:0]  GPM_SEL_4         = 3'h4;
    localparam logic [2:0]  GPM_SEL_5         = 3'h5;
    localparam logic [2:0]  GPM_SEL_6         = 3'h6;
    localparam logic [2:0]  GPM_SEL_7         = 3'h7;

    // control register layout
    typedef struct packed {
        logic [2:0] pin3_signal_select;
        logic [2:0] pin3_source_group;
        logic       pin3_local_level;
        logic       pin3_drive_enable;
    } gpm_ctl_t;

    // per receive port status
    typedef struct packed {
        logic [3:0] remote_gpio;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } gpm_rx_t;

    // transmit port status
    typedef struct packed {
        logic pass_and;
        logic pass_or;
        logic frame_valid;
        logic line_valid;
        logic synced;
        logic tx_irq;
    } gpm_tx_t;

endpackage

// ### gpm_pin3_mux.sv
// Notes on behaviour
// - the pin is driven only while the drive enable bit 0 is one.
// - source bits 4:2 pick rx port 0..3, device status (100) or tx port (110).
// - for an rx port, select bits 7:5 pick remote gpio 0..3, lock, pass, fv, lv.
// - for device status, 000 local level, 001 or lock, 010 and lock, 011 and pass, 100 sync.
// - device status codes 101..111 are reserved and give a low output here.
// - for tx port, 000 and pass, 001 or pass, 010 fv, 011 lv, 100 synced, 101 irq.
// - value bit 1 is the level driven when the local level is selected.
// - the control register resets to zero and all fields read back as written.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module gpm_pin3_mux
    import gpm_pkg::*;
#(
    parameter int NPORT = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             srst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output var  logic [31:0]      prdata,
    output var  logic             pready,
    output var  logic             pslverr,
    input  wire gpm_rx_t [NPORT-1:0] rx_status,
    input  wire logic [NPORT-1:0] port_enabled,
    input  wire logic             frame_sync_pulse,
    input  wire gpm_tx_t          tx_status,
    output var  logic             pin3_out,
    output var  logic             pin3_oe_n
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    localparam int SW = NPORT * $bits(gpm_rx_t) + NPORT + 1 + $bits(gpm_tx_t);
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;

    // two flops on every status input from other domains
    always_ff @(posedge sys_clk) begin
        sync1_reg <= {rx_status, port_enabled, frame_sync_pulse, tx_status};
        sync2_reg <= sync1_reg;
    end

    gpm_rx_t [NPORT-1:0] rx_s;
    logic [NPORT-1:0]    en_s;
    logic                fs_s;
    gpm_tx_t             tx_s;
    assign {rx_s, en_s, fs_s, tx_s} = sync2_reg;

    // ------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------
    gpm_ctl_t ctl_reg;
    logic     hit;
    logic     access;
    assign hit    = (paddr == GPM_CTL_ADDR);
    assign access = psel && penable && pready;

    // zero-wait-state ready: high in the access cycle only
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !pready;
        end
    end

    // control register write
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctl_reg <= gpm_ctl_t'(GPM_CTL_RESET);
        end else if (access && pwrite && hit) begin
            ctl_reg <= gpm_ctl_t'(pwdata[7:0]);
        end
    end

    // read data and error, registered in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && !pready) begin
            prdata  <= (hit && !pwrite) ? {24'h00_0000, ctl_reg} : 32'h0000_0000;
            pslverr <= !hit;
        end
    end

    // ------------------------------------------------------------------
    // signal selection
    // ------------------------------------------------------------------
    logic lock_or;
    logic lock_and;
    logic pass_and;
    logic [NPORT-1:0] lk_v;
    logic [NPORT-1:0] ps_v;

    // per port lock and pass, masked by port enable
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            assign lk_v[gi] = rx_s[gi].lock;
            assign ps_v[gi] = rx_s[gi].pass;
        end
    endgenerate

    assign lock_or  = |(lk_v & en_s);
    assign lock_and = (|en_s) && &(lk_v | ~en_s);
    assign pass_and = (|en_s) && &(ps_v | ~en_s);

    logic    sel_next;
    gpm_rx_t rx_sel;
    assign rx_sel = rx_s[ctl_reg.pin3_source_group[1:0]];

    // group then signal choice
    always_comb begin
        sel_next = 1'b0;
        if (!ctl_reg.pin3_source_group[2]) begin
            case (ctl_reg.pin3_signal_select)
                GPM_SEL_0: sel_next = rx_sel.remote_gpio[0];
                GPM_SEL_1: sel_next = rx_sel.remote_gpio[1];
                GPM_SEL_2: sel_next = rx_sel.remote_gpio[2];
                GPM_SEL_3: sel_next = rx_sel.remote_gpio[3];
                GPM_SEL_4: sel_next = rx_sel.lock;
                GPM_SEL_5: sel_next = rx_sel.pass;
                GPM_SEL_6: sel_next = rx_sel.frame_valid;
                default:   sel_next = rx_sel.line_valid;
            endcase
        end else if (ctl_reg.pin3_source_group == GPM_SRC_STATUS) begin
            case (ctl_reg.pin3_signal_select)
                GPM_SEL_0: sel_next = ctl_reg.pin3_local_level;
                GPM_SEL_1: sel_next = lock_or;
                GPM_SEL_2: sel_next = lock_and;
                GPM_SEL_3: sel_next = pass_and;
                GPM_SEL_4: sel_next = fs_s;
                default:   sel_next = 1'b0;
            endcase
        end else if (ctl_reg.pin3_source_group == GPM_SRC_TX) begin
            case (ctl_reg.pin3_signal_select)
                GPM_SEL_0: sel_next = tx_s.pass_and;
                GPM_SEL_1: sel_next = tx_s.pass_or;
                GPM_SEL_2: sel_next = tx_s.frame_valid;
                GPM_SEL_3: sel_next = tx_s.line_valid;
                GPM_SEL_4: sel_next = tx_s.synced;
                GPM_SEL_5: sel_next = tx_s.tx_irq;
                default:   sel_next = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------------
    // level and enable registered; output disabled holds level low
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pin3_out  <= 1'b0;
            pin3_oe_n <= 1'b1;
        end else begin
            pin3_out  <= ctl_reg.pin3_drive_enable ? sel_next : 1'b0;
            pin3_oe_n <= !ctl_reg.pin3_drive_enable;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    drive_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
        pin3_oe_n == !$past(ctl_reg.pin3_drive_enable))
        else $error("pin drive does not follow enable");
    release_off_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(!ctl_reg.pin3_drive_enable) |-> pin3_oe_n && !pin3_out)
        else $error("pin driven while disabled");
    local_level_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(ctl_reg.pin3_drive_enable && ctl_reg.pin3_source_group == GPM_SRC_STATUS
              && ctl_reg.pin3_signal_select == GPM_SEL_0)
        |-> pin3_out == $past(ctl_reg.pin3_local_level))
        else $error("local level not driven");
    status_rsv_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(ctl_reg.pin3_source_group == GPM_SRC_STATUS
              && ctl_reg.pin3_signal_select > GPM_SEL_4) |-> !pin3_out)
        else $error("reserved status code not low");
    rx_lock_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(ctl_reg.pin3_drive_enable && !ctl_reg.pin3_source_group[2]
              && ctl_reg.pin3_signal_select == GPM_SEL_4) |-> pin3_out == $past(rx_sel.lock))
        else $error("rx lock not routed");
    tx_irq_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(ctl_reg.pin3_drive_enable && ctl_reg.pin3_source_group == GPM_SRC_TX
              && ctl_reg.pin3_signal_select == GPM_SEL_5) |-> pin3_out == $past(tx_s.tx_irq))
        else $error("tx interrupt not routed");
    src_rsv_a: assert property (@(posedge sys_clk) disable iff (srst)
        $past(ctl_reg.pin3_source_group == GPM_SEL_5 || ctl_reg.pin3_source_group == GPM_SEL_7)
        |-> !pin3_out)
        else $error("reserved source not low");
    ctl_write_a: assert property (@(posedge sys_clk) disable iff (srst)
        access && pwrite && hit |=> ctl_reg == gpm_ctl_t'($past(pwdata[7:0])))
        else $error("control write lost");
    ctl_reset_a: assert property (@(posedge sys_clk)
        srst |=> ctl_reg == gpm_ctl_t'(GPM_CTL_RESET) && pin3_oe_n)
        else $error("control reset wrong");
    // rx remote gpio 0 and frame sync routes, reserved tx codes and the read path
    rx_gpio_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctl_reg.pin3_drive_enable && !ctl_reg.pin3_source_group[2]
        && ctl_reg.pin3_signal_select == GPM_SEL_0
        |=> pin3_out == $past(rx_sel.remote_gpio[0]))
        else $error("rx remote gpio not routed");
    frame_sync_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctl_reg.pin3_drive_enable && ctl_reg.pin3_source_group == GPM_SRC_STATUS
        && ctl_reg.pin3_signal_select == GPM_SEL_4 |=> pin3_out == $past(fs_s))
        else $error("frame sync not routed");
    tx_rsv_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctl_reg.pin3_source_group == GPM_SRC_TX && ctl_reg.pin3_signal_select > GPM_SEL_5
        |=> !pin3_out)
        else $error("reserved tx code not low");
    read_data_a: assert property (@(posedge sys_clk) disable iff (srst)
        psel && !pready && hit && !pwrite |=> prdata == {24'h00_0000, $past(ctl_reg)})
        else $error("read data wrong");

    drive_on_c: cover property (@(posedge sys_clk) disable iff (srst) !pin3_oe_n && pin3_out);
    tx_src_c:   cover property (@(posedge sys_clk) disable iff (srst)
        ctl_reg.pin3_source_group == GPM_SRC_TX && !pin3_oe_n);
    read_c:     cover property (@(posedge sys_clk) disable iff (srst) access && !pwrite && hit);
    rsv_code_c: cover property (@(posedge sys_clk) disable iff (srst)
        ctl_reg.pin3_source_group == GPM_SRC_STATUS && ctl_reg.pin3_signal_select > GPM_SEL_4);
    lock_and_c: cover property (@(posedge sys_clk) disable iff (srst) lock_and && !pin3_oe_n);

endmodule
`default_nettype wire

// ### gpm_pin_board.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// board net on pin 3 with a weak pull
// ------------------------------------------------------------
module gpm_pin_board #(
    parameter logic PULL_LEVEL = 1'b0
) (
    input  wire logic pin3_out,
    input  wire logic pin3_oe_n,
    output var  logic pin_level
);
    // the pull sets the net whenever the device lets go of it
    assign pin_level = pin3_oe_n ? PULL_LEVEL : pin3_out;
endmodule
`default_nettype wire

// ### test_gpio_pin3_output_mux.sv
`timescale 1ns/1ns
`default_nettype none
module test_gpio_pin3_output_mux
    import gpm_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and design
    // ------------------------------------------------------------
    logic          sys_clk, srst, psel, penable, pwrite, frame_sync_pulse;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          pready, pslverr, pin3_out, pin3_oe_n, pin_level, err;
    gpm_rx_t [3:0] rx_status;
    logic [3:0]    port_enabled;
    gpm_tx_t       tx_status;
    int            n_mismatch, check_count, cyc;

    gpm_pin3_mux #(.NPORT(4)) dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_status(rx_status),
        .port_enabled(port_enabled), .frame_sync_pulse(frame_sync_pulse),
        .tx_status(tx_status), .pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n));
    gpm_pin_board board_u (.pin3_out(pin3_out), .pin3_oe_n(pin3_oe_n),
        .pin_level(pin_level));

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // a hang ends the run with a mismatch
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge sys_clk);
        end
        if (n == 20) check(0, 1, "no pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // program the control byte, let it settle, judge the pin
    task automatic pin(input logic [7:0] ctl, input logic exp);
        apb(1'b1, GPM_CTL_ADDR, {24'h0, ctl});
        repeat (4) @(posedge sys_clk);
        check({31'h0, pin3_oe_n}, {31'h0, ~ctl[0]}, "drive enable");
        check({31'h0, pin_level}, {31'h0, exp}, "pin level");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_regs;
        apb(1'b0, GPM_CTL_ADDR, 32'h0);
        check(rd, 32'h0000_0000, "reset value");
        check({31'h0, pin3_oe_n}, 32'h1, "released after reset");
        apb(1'b1, GPM_CTL_ADDR, 32'hFFFF_FFFE);
        apb(1'b1, 12'h050, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped write");
        apb(1'b0, GPM_CTL_ADDR, 32'h0);
        check(rd, 32'h0000_00FE, "read back");
        apb(1'b0, 12'h050, 32'h0);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        $display("test regs done");
    endtask

    task automatic test_rx;
        logic [7:0]  pat;
        logic [31:0] all;
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 8; s++) begin
                for (int v = 0; v < 2; v++) begin
                    pat = 8'h01 << ((s < 4) ? 4 + s : 7 - s);
                    pat = v ? pat : ~pat;
                    all = {4{~pat}};
                    all[p*8 +: 8] = pat;
                    rx_status <= all;
                    pin({s[2:0], p[2:0], 2'b01}, v[0]);
                end
            end
        end
        $display("test rx done");
    endtask

    task automatic st(input logic [31:0] rx, input logic fs, input logic [3:0] sv,
                      input logic exp);
        rx_status <= rx;
        frame_sync_pulse <= fs;
        pin({sv[3:1], GPM_SRC_STATUS, sv[0], 1'b1}, exp);
    endtask

    task automatic test_status;
        port_enabled <= 4'b0101;
        st(32'h0, 1'b1, 4'h1, 1'b1);
        st(32'hFFFF_FFFF, 1'b1, 4'h0, 1'b0);
        st(32'h0008_0000, 1'b0, 4'h2, 1'b1);
        st(32'h0800_0800, 1'b1, 4'h2, 1'b0);
        st(32'h0008_0008, 1'b0, 4'h4, 1'b1);
        st(32'h0000_0008, 1'b1, 4'h4, 1'b0);
        st(32'h0004_0004, 1'b0, 4'h6, 1'b1);
        st(32'h0000_0004, 1'b1, 4'h6, 1'b0);
        st(32'h0, 1'b1, 4'h8, 1'b1);
        st(32'hFFFF_FFFF, 1'b0, 4'h8, 1'b0);
        $display("test status done");
    endtask

    task automatic test_tx;
        logic [5:0] oh;
        for (int s = 0; s < 6; s++) begin
            for (int v = 0; v < 2; v++) begin
                oh = 6'h20 >> s;
                tx_status <= v ? oh : ~oh;
                pin({s[2:0], GPM_SRC_TX, 2'b01}, v[0]);
            end
        end
        pin({3'h0, GPM_SRC_TX, 2'b10}, 1'b0);
        pin({3'h0, GPM_SRC_STATUS, 2'b10}, 1'b0);
        $display("test tx and release done");
    endtask

    // reserved codes stay low with every status input high, as do or lock and and lock with no port enabled
    task automatic test_reserved;
        rx_status <= '1;
        tx_status <= '1;
        frame_sync_pulse <= 1'b1;
        port_enabled <= 4'hF;
        pin({3'h0, 3'h5, 2'b11}, 1'b0);
        pin({3'h4, 3'h7, 2'b11}, 1'b0);
        for (int s = 5; s < 8; s++) begin
            pin({s[2:0], GPM_SRC_STATUS, 2'b11}, 1'b0);
        end
        pin({GPM_SEL_6, GPM_SRC_TX, 2'b01}, 1'b0);
        pin({GPM_SEL_7, GPM_SRC_TX, 2'b01}, 1'b0);
        port_enabled <= 4'h0;
        st(32'hFFFF_FFFF, 1'b1, 4'h2, 1'b0);
        st(32'hFFFF_FFFF, 1'b1, 4'h4, 1'b0);
        $display("test reserved done");
    endtask

    // a reset in mid-run clears a programmed control register
    task automatic test_reset;
        apb(1'b1, GPM_CTL_ADDR, 32'h0000_00FF);
        @(posedge sys_clk);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        apb(1'b0, GPM_CTL_ADDR, 32'h0);
        check(rd, 32'h0000_0000, "value after mid-run reset");
        check({31'h0, pin3_oe_n}, 32'h1, "released after mid-run reset");
        $display("test reset done");
    endtask

    // ------------------------------------------------------------
    // verdict
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        srst = 1'b1;
        {psel, penable, pwrite, frame_sync_pulse} = 4'h0;
        {paddr, pwdata, rx_status, port_enabled, tx_status} = '0;
        {n_mismatch, check_count, cyc} = '0;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        test_regs();
        test_rx();
        test_status();
        test_tx();
        test_reserved();
        test_reset();
        conclude();
    end
endmodule
`default_nettype wire
